// *** common/bcdcnt_pkg.sv ***
// Shared constants and types for the BCD up/down event counter bank.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package bcdcnt_pkg;

  // Bank geometry: one 16-bit storage word per counter number.
  localparam int             CNT_NUM     = 256;
  localparam int             IDX_W       = 8;
  localparam int             WORD_W      = 16;
  localparam int             CNT_W       = 10;
  localparam int             DIGIT_W     = 4;
  localparam int             BCD_W       = 12;

  // Count limits and reset values.
  localparam logic [CNT_W-1:0]   CNT_MAX     = 10'h3E7;
  localparam logic [CNT_W-1:0]   CNT_ZERO    = 10'h000;
  localparam logic [CNT_W-1:0]   CNT_ONE     = 10'h001;
  localparam logic [WORD_W-1:0]  WORD_RST    = 16'h0000;
  localparam logic [IDX_W-1:0]   IDX_LAST    = 8'hFF;
  localparam logic [IDX_W-1:0]   IDX_ZERO    = 8'h00;

  // Decimal digit handling.
  localparam logic [DIGIT_W-1:0] DIGIT_MAX   = 4'h9;
  localparam logic [CNT_W-1:0]   WEIGHT_HUND = 10'h064;
  localparam logic [CNT_W-1:0]   WEIGHT_TEN  = 10'h00A;

  // Field positions inside the BCD word.
  localparam int             DIG0_LSB    = 0;
  localparam int             DIG1_LSB    = 4;
  localparam int             DIG2_LSB    = 8;

  // Edge history bits kept per counter.
  localparam int             HIST_W      = 4;
  localparam int             HIST_UP     = 0;
  localparam int             HIST_DN     = 1;
  localparam int             HIST_SET    = 2;
  localparam int             HIST_CLR    = 3;
  localparam logic [HIST_W-1:0]  HIST_RST    = 4'h0;

  // Which box the evaluation stands for.
  typedef enum logic {
    VAR_UPDOWN = 1'b0,
    VAR_UPONLY = 1'b1
  } bcdcnt_variant_t;

  // Controller state: storage sweep after reset, then normal service.
  typedef enum logic [1:0] {
    ST_SWEEP = 2'b00,
    ST_RUN   = 2'b01
  } bcdcnt_state_t;

endpackage

// *** common/bcdcnt_conv_if.sv ***
// Carrier between the counter bank and its number-format converter.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/10ps
interface bcdcnt_conv_if;
  import bcdcnt_pkg::*;

  logic [CNT_W-1:0]  count_bin;     // binary count to be shown in decimal
  logic [BCD_W-1:0]  count_bcd;     // three decimal digits of count_bin
  logic [WORD_W-1:0] preload_bcd;   // raw preload word, BCD coded
  logic [CNT_W-1:0]  preload_bin;   // preload as a binary count

  modport bank (
    output count_bin,
    output preload_bcd,
    input  count_bcd,
    input  preload_bin
  );

  modport conv (
    input  count_bin,
    input  preload_bcd,
    output count_bcd,
    output preload_bin
  );
endinterface

// *** rtl/bcdcnt_conv.sv ***
// Combinational binary/BCD conversion for the counter bank.
// Assumes count_bin never exceeds 999, which the bank guarantees.
`timescale 1ns/10ps
module bcdcnt_conv
  import bcdcnt_pkg::*;
(
  bcdcnt_conv_if.conv link // conversion requests and results
);

  logic [DIGIT_W-1:0] hund;
  logic [DIGIT_W-1:0] tens;
  logic [DIGIT_W-1:0] ones;
  logic [CNT_W-1:0]   rem_h;
  logic [DIGIT_W-1:0] pd2;
  logic [DIGIT_W-1:0] pd1;
  logic [DIGIT_W-1:0] pd0;

  // Binary to three decimal digits.
  always_comb begin
    hund  = DIGIT_W'(link.count_bin / WEIGHT_HUND);
    rem_h = CNT_W'(link.count_bin % WEIGHT_HUND);
    tens  = DIGIT_W'(rem_h / WEIGHT_TEN);
    ones  = DIGIT_W'(rem_h % WEIGHT_TEN);
    link.count_bcd = {hund, tens, ones};
  end

  // Preload digits above nine are clamped so the result stays within 999.
  always_comb begin
    pd2 = link.preload_bcd[DIG2_LSB +: DIGIT_W];
    pd1 = link.preload_bcd[DIG1_LSB +: DIGIT_W];
    pd0 = link.preload_bcd[DIG0_LSB +: DIGIT_W];
    if (pd2 > DIGIT_MAX) begin
      pd2 = DIGIT_MAX;
    end
    if (pd1 > DIGIT_MAX) begin
      pd1 = DIGIT_MAX;
    end
    if (pd0 > DIGIT_MAX) begin
      pd0 = DIGIT_MAX;
    end
    link.preload_bin = CNT_W'(CNT_W'(pd2) * WEIGHT_HUND + CNT_W'(pd1) * WEIGHT_TEN + CNT_W'(pd0));
  end

endmodule

// *** rtl/bcdcnt_top.sv ***
// Bank of 256 event counters, range 0 to 999, up/down and up-only boxes.
// Assumes the program logic presents one evaluation per cycle, synchronous to clk.
// Requests wait on eval_ready while the storage is swept after each reset.
// Result outputs are registered; all but result_valid hold until the next accepted evaluation.
//
// Notes on behaviour
// - one 16-bit storage word per counter.
// - 256 independent counters, addressed by number.
// - only counter logic touches counter storage.
// - binary count in word bits 0 to 9.
// - count always stays within 0 to 999.
// - BCD count occupies bits 0 to 11.
// - set moves count value into the word.
// - rising set edge loads the preload value.
// - up/down box clears while reset is high.
// - rising up edge adds one below 999.
// - rising down edge subtracts one above 0.
// - both edges together leave count unchanged.
// - nonzero flag high exactly when count above 0.
// - up-only box clears on reset rising edge.
// - up-only box counts up edges below 999.
// - count shown as 16-bit binary word.
// - count shown as 16-bit BCD word.
`timescale 1ns/10ps
module bcdcnt_top
  import bcdcnt_pkg::*;
(
  input  wire logic              clk,                // 100 MHz scan clock
  input  wire logic              reset_n,            // synchronous reset, active low
  input  wire logic              eval_valid,         // evaluation request present
  output logic                   eval_ready,         // bank accepts evaluations
  input  wire logic [IDX_W-1:0]  eval_index,         // counter number to evaluate
  input  wire bcdcnt_variant_t   eval_variant,       // up/down or up-only box
  input  wire logic              count_up_pulse,     // count-up input level
  input  wire logic              count_down_pulse,   // count-down input level
  input  wire logic              preset_in,          // set input level
  input  wire logic              clear_in,           // reset input level
  input  wire logic [WORD_W-1:0] preload_value,      // preset value, BCD coded
  output logic                   result_valid,       // outputs below are fresh
  output logic [IDX_W-1:0]       result_index,       // counter number of the result
  output logic [WORD_W-1:0]      count_binary_out,   // count, binary integer
  output logic [WORD_W-1:0]      count_decimal_out,  // count, BCD
  output logic                   nonzero_flag        // count above zero
);

  logic [WORD_W-1:0] count_mem [CNT_NUM];
  logic [HIST_W-1:0] hist_mem  [CNT_NUM];

  bcdcnt_state_t     state_ff;
  bcdcnt_state_t     nxt_state;
  logic [IDX_W-1:0]  sweep_idx_ff;
  logic [IDX_W-1:0]  nxt_sweep_idx;

  logic              take;
  logic [WORD_W-1:0] cur_word;
  logic [CNT_W-1:0]  cur_count;
  logic [HIST_W-1:0] cur_hist;
  logic [HIST_W-1:0] nxt_hist;
  logic [HIST_W-1:0] in_lvl;
  logic [HIST_W-1:0] edge_vec;
  logic              up_edge;
  logic              dn_edge;
  logic              set_edge;
  logic              clr_edge;
  logic              clr_now;
  logic              at_max;
  logic              at_zero;
  logic [CNT_W-1:0]  nxt_count;
  logic [WORD_W-1:0] nxt_word;

  logic              result_valid_ff;
  logic [IDX_W-1:0]  result_index_ff;
  logic [WORD_W-1:0] count_binary_ff;
  logic [WORD_W-1:0] count_decimal_ff;
  logic              nonzero_ff;

  bcdcnt_conv_if conv_bus ();

  bcdcnt_conv u_conv (
    .link (conv_bus.conv)
  );

  // The storage is swept to zero after reset instead of being cleared in
  // one cycle, so that the bank maps onto a plain RAM without a reset port.
  always_comb begin
    nxt_state     = state_ff;
    nxt_sweep_idx = sweep_idx_ff;
    case (state_ff)
      ST_SWEEP: begin
        nxt_sweep_idx = IDX_W'(sweep_idx_ff + 1'b1);
        if (sweep_idx_ff == IDX_LAST) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state     = ST_SWEEP;
        nxt_sweep_idx = IDX_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_SWEEP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The sweep index restarts on every reset, so a reset that lands in
  // mid-sweep still leaves every counter cleared once it is released.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sweep_idx_ff <= IDX_ZERO;
    end else begin
      sweep_idx_ff <= nxt_sweep_idx;
    end
  end

  // A reset that lands in service must stop requests at once, before the
  // state register has fallen back to the sweep.
  always_comb begin
    eval_ready = reset_n && (state_ff == ST_RUN);
    take       = eval_valid && eval_ready;
  end

  // Read the addressed counter's word and input history.
  // The storage is read without a register, so a request right after a write
  // to the same counter sees the new word; a registered RAM would need a bypass.
  always_comb begin
    cur_word  = count_mem[eval_index];
    cur_hist  = hist_mem[eval_index];
    cur_count = cur_word[CNT_W-1:0];
  end

  // Input levels in history bit order.
  always_comb begin
    in_lvl           = HIST_RST;
    in_lvl[HIST_UP]  = count_up_pulse;
    in_lvl[HIST_DN]  = count_down_pulse;
    in_lvl[HIST_SET] = preset_in;
    in_lvl[HIST_CLR] = clear_in;
  end

  // compare with stored history
  // The down history is kept for the up-only box too, so a counter that
  // changes box between evaluations does not see a false down edge.
  for (genvar gi = 0; gi < HIST_W; gi++) begin : g_edge
    assign edge_vec[gi] = in_lvl[gi] && !cur_hist[gi];
    assign nxt_hist[gi] = in_lvl[gi];
  end

  always_comb begin
    up_edge  = edge_vec[HIST_UP];
    dn_edge  = edge_vec[HIST_DN] && (eval_variant == VAR_UPDOWN);
    set_edge = edge_vec[HIST_SET];
    clr_edge = edge_vec[HIST_CLR];
  end

  // edge clear on up-only box
  // In the up/down box a level clear outranks every other input for as long as it stays high.
  always_comb begin
    if (eval_variant == VAR_UPDOWN) begin
      clr_now = clear_in;
    end else begin
      clr_now = clr_edge;
    end
  end

  always_comb begin
    conv_bus.preload_bcd = preload_value;
  end

  // Saturation limits of the addressed counter.
  always_comb begin
    at_max  = (cur_count >= CNT_MAX);
    at_zero = (cur_count == CNT_ZERO);
  end

  // Clear takes priority over set, and set over counting. A set edge that
  // comes with count edges loads the preset and drops them, so the loaded
  // value is always what the next scan reads back.
  always_comb begin
    nxt_count = cur_count;
    if (clr_now) begin
      nxt_count = CNT_ZERO;
    end else if (set_edge) begin
      nxt_count = conv_bus.preload_bin;
    end else if (up_edge && dn_edge) begin
      nxt_count = cur_count;
    end else if (up_edge) begin
      if (!at_max) begin
        nxt_count = CNT_W'(cur_count + CNT_ONE);
      end
    end else if (dn_edge) begin
      if (!at_zero) begin
        nxt_count = CNT_W'(cur_count - CNT_ONE);
      end
    end
    // keep within range
    // Only a damaged storage word could exceed the limit; the clamp keeps
    // such a word from ever reaching the outputs.
    if (nxt_count > CNT_MAX) begin
      nxt_count = CNT_MAX;
    end
  end

  // Bits above the count are written as zero, so the binary output needs
  // no masking downstream.
  always_comb begin
    nxt_word = WORD_RST;
    nxt_word[CNT_W-1:0] = nxt_count;
    conv_bus.count_bin  = nxt_count;
  end

  // Counter word storage: swept after reset, then written per evaluation.
  // A request is taken only in service, so the sweep never races a write.
  always_ff @(posedge clk) begin
    if (state_ff == ST_SWEEP) begin
      count_mem[sweep_idx_ff] <= WORD_RST;
    end else if (take) begin
      count_mem[eval_index] <= nxt_word;
    end
  end

  // Input history storage; a fresh counter starts with all inputs low.
  always_ff @(posedge clk) begin
    if (state_ff == ST_SWEEP) begin
      hist_mem[sweep_idx_ff] <= HIST_RST;
    end else if (take) begin
      hist_mem[eval_index] <= nxt_hist;
    end
  end

  // Result strobe: one cycle after each accepted evaluation.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= take;
    end
  end

  // The index holds with the data, so a late reader still knows whose count it sees.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result_index_ff <= IDX_ZERO;
    end else if (take) begin
      result_index_ff <= eval_index;
    end
  end

  // Results hold until the next accepted evaluation.
  // binary word output
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_binary_ff <= WORD_RST;
    end else if (take) begin
      count_binary_ff <= nxt_word;
    end
  end

  // BCD in bits 0 to 11
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_decimal_ff <= WORD_RST;
    end else if (take) begin
      count_decimal_ff <= {{(WORD_W-BCD_W){1'b0}}, conv_bus.count_bcd};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nonzero_ff <= 1'b0;
    end else if (take) begin
      nonzero_ff <= (nxt_count != CNT_ZERO);
    end
  end

  always_comb begin
    result_valid      = result_valid_ff;
    result_index      = result_index_ff;
    count_binary_out  = count_binary_ff;
    count_decimal_out = count_decimal_ff;
    nonzero_flag      = nonzero_ff;
  end

endmodule

// *** test/bcdcnt_top_properties.sv ***
// Checker for the counter bank top module, bound after the module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module bcdcnt_top_properties
  import bcdcnt_pkg::*;
(
  input wire logic              clk,               // clock
  input wire logic              reset_n,           // reset
  input wire logic              eval_valid,        // request
  input wire logic              eval_ready,        // accept
  input wire logic [IDX_W-1:0]  eval_index,        // number
  input wire bcdcnt_variant_t   eval_variant,      // box
  input wire logic              count_up_pulse,    // up
  input wire logic              count_down_pulse,  // down
  input wire logic              preset_in,         // set
  input wire logic              clear_in,          // clear
  input wire logic [WORD_W-1:0] preload_value,     // preset
  input wire logic              result_valid,      // result
  input wire logic [IDX_W-1:0]  result_index,      // number
  input wire logic [WORD_W-1:0] count_binary_out,  // binary
  input wire logic [WORD_W-1:0] count_decimal_out, // BCD
  input wire logic              nonzero_flag       // nonzero
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = eval_valid && eval_ready;

  a_result_next: assert property (take |=> result_valid && result_index == $past(eval_index))
    else $error("result missing after accepted request");
  a_result_idle: assert property (!take |=> !result_valid)
    else $error("result without accepted request");
  a_range_max: assert property (result_valid |-> count_binary_out <= 16'h03E7)
    else $error("count above upper limit");
  a_flag_nonzero: assert property (result_valid |-> nonzero_flag == (count_binary_out != 16'h0000))
    else $error("nonzero flag disagrees with count");
  a_bcd_match: assert property (result_valid |-> count_decimal_out == {4'h0, 4'(count_binary_out / 16'h0064),
      4'(count_binary_out / 16'h000A % 16'h000A), 4'(count_binary_out % 16'h000A)})
    else $error("decimal output disagrees with binary");
  a_clear_level: assert property (take && clear_in && eval_variant == VAR_UPDOWN
      |=> count_binary_out == 16'h0000 && !nonzero_flag)
    else $error("level clear did not zero the count");
  a_hold_data: assert property (!result_valid |-> $stable(count_binary_out) && $stable(nonzero_flag))
    else $error("outputs moved without a result");
  a_ready_sweep: assert property ($rose(reset_n) |-> !eval_ready [*8])
    else $error("requests accepted during storage sweep");

  c_top_count: cover property (result_valid && count_binary_out == 16'h03E7);
  c_clear: cover property (take && clear_in);
  c_both: cover property (take && count_up_pulse && count_down_pulse);
endmodule

bind bcdcnt_top bcdcnt_top_properties u_props (
  .clk(clk), .reset_n(reset_n), .eval_valid(eval_valid), .eval_ready(eval_ready),
  .eval_index(eval_index), .eval_variant(eval_variant), .count_up_pulse(count_up_pulse),
  .count_down_pulse(count_down_pulse), .preset_in(preset_in), .clear_in(clear_in),
  .preload_value(preload_value), .result_valid(result_valid), .result_index(result_index),
  .count_binary_out(count_binary_out), .count_decimal_out(count_decimal_out), .nonzero_flag(nonzero_flag)
);

// *** test/bcdcnt_prog_model.sv ***
// Program-logic model: issues one evaluation at a time into the bank.
// Assumes the bench calls eval; inputs move on the falling edge.
`timescale 1ns/10ps
module bcdcnt_prog_model
  import bcdcnt_pkg::*;
(
  input  wire logic              clk,              // bank clock
  input  wire logic              eval_ready,       // bank accepts
  output logic                   eval_valid,       // request
  output logic [IDX_W-1:0]       eval_index,       // number
  output bcdcnt_variant_t        eval_variant,     // box
  output logic                   count_up_pulse,   // up level
  output logic                   count_down_pulse, // down level
  output logic                   preset_in,        // set level
  output logic                   clear_in,         // clear level
  output logic [WORD_W-1:0]      preload_value     // BCD preset
);
  initial begin
    eval_valid = 1'b0;
    eval_index = 8'h00;
    eval_variant = VAR_UPDOWN;
    {clear_in, preset_in, count_down_pulse, count_up_pulse} = 4'h0;
    preload_value = 16'h0000;
  end

  // Levels {clear, set, down, up} persist, as program inputs do between scans.
  task automatic eval(input logic [IDX_W-1:0] idx, input bcdcnt_variant_t vk, input logic [3:0] lv,
                      input logic [WORD_W-1:0] pre);
    @(negedge clk);
    eval_valid = 1'b1;
    eval_index = idx;
    eval_variant = vk;
    {clear_in, preset_in, count_down_pulse, count_up_pulse} = lv;
    preload_value = pre;
    // Ready is looked at on the falling edge, where it has settled; it moves
    // on a rising edge or when reset_n drops, so the next rising edge takes the request.
    while (eval_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    eval_valid = 1'b0;
    // Stale index and preset are scrambled so late sampling is caught.
    eval_index = ~idx;
    preload_value = ~pre;
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the counter bank.
// Assumes the program-logic model drives every evaluation input.
`timescale 1ns/10ps
module testbench;
  import bcdcnt_pkg::*;
  localparam logic [3:0] NO = 4'h0;
  localparam logic [3:0] UP = 4'h1;
  localparam logic [3:0] DN = 4'h2;
  localparam logic [3:0] ST = 4'h4;
  localparam logic [3:0] CL = 4'h8;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              eval_valid, eval_ready, result_valid, nonzero_flag;
  logic              count_up_pulse, count_down_pulse, preset_in, clear_in;
  bcdcnt_variant_t   eval_variant;
  logic [IDX_W-1:0]  eval_index, result_index;
  logic [WORD_W-1:0] preload_value, count_binary_out, count_decimal_out;
  int                fails = 0;
  int                compares = 0;
  int                cycles = 0;

  bcdcnt_top u_dut (
    .clk(clk), .reset_n(reset_n), .eval_valid(eval_valid), .eval_ready(eval_ready),
    .eval_index(eval_index), .eval_variant(eval_variant), .count_up_pulse(count_up_pulse),
    .count_down_pulse(count_down_pulse), .preset_in(preset_in), .clear_in(clear_in),
    .preload_value(preload_value), .result_valid(result_valid), .result_index(result_index),
    .count_binary_out(count_binary_out), .count_decimal_out(count_decimal_out), .nonzero_flag(nonzero_flag)
  );
  bcdcnt_prog_model u_prog (
    .clk(clk), .eval_ready(eval_ready), .eval_valid(eval_valid), .eval_index(eval_index),
    .eval_variant(eval_variant), .count_up_pulse(count_up_pulse), .count_down_pulse(count_down_pulse),
    .preset_in(preset_in), .clear_in(clear_in), .preload_value(preload_value)
  );

  always #5 clk = ~clk;

  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      fails++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One evaluation, then the result is judged in the cycle it stands.
  task automatic ev(input logic [IDX_W-1:0] idx, input bcdcnt_variant_t vk, input logic [3:0] lv,
                    input logic [WORD_W-1:0] pre, input int exp);
    u_prog.eval(idx, vk, lv, pre);
    check("result_valid", {15'h0000, result_valid}, 16'h0001);
    check("result_index", {8'h00, result_index}, {8'h00, idx});
    check("count_binary_out", count_binary_out, 16'(exp));
    check("count_decimal_out", count_decimal_out,
          {4'h0, 4'(exp / 32'h64), 4'(exp / 32'hA % 32'hA), 4'(exp % 32'hA)});
    check("nonzero_flag", {15'h0000, nonzero_flag}, {15'h0000, exp != 32'h0});
  endtask

  task automatic t_walk();
    ev(8'h05, VAR_UPDOWN, UP, 16'h0000, 1);
    ev(8'h05, VAR_UPDOWN, UP, 16'h0000, 1);
    ev(8'h05, VAR_UPDOWN, NO, 16'h0000, 1);
    ev(8'h05, VAR_UPDOWN, UP, 16'h0000, 2);
  endtask

  task automatic t_preset();
    ev(8'h07, VAR_UPDOWN, ST, 16'h0127, 127);
    ev(8'h07, VAR_UPDOWN, ST, 16'h0500, 127);
    ev(8'h08, VAR_UPDOWN, NO, 16'h0000, 0);
    ev(8'hFF, VAR_UPDOWN, UP, 16'h0000, 1);
    ev(8'h0C, VAR_UPDOWN, ST, 16'hF1AF, 199);
  endtask

  // Ready rises only once every counter has been swept to zero.
  task automatic t_sweep();
    repeat (CNT_NUM - 1) @(negedge clk);
    check("eval_ready", {15'h0000, eval_ready}, 16'h0000);
    @(negedge clk);
    check("eval_ready", {15'h0000, eval_ready}, 16'h0001);
  endtask

  // A reset in service stops requests at once and sweeps the bank again.
  task automatic t_reset();
    @(negedge clk);
    reset_n = 1'b0;
    #1;
    check("eval_ready", {15'h0000, eval_ready}, 16'h0000);
    @(negedge clk);
    check("result_valid", {15'h0000, result_valid}, 16'h0000);
    check("count_binary_out", count_binary_out, 16'h0000);
    @(negedge clk);
    reset_n = 1'b1;
    t_sweep();
    ev(8'h05, VAR_UPDOWN, UP, 16'h0000, 1);
  endtask

  task automatic t_limits();
    ev(8'h09, VAR_UPDOWN, ST, 16'h0999, 999);
    ev(8'h09, VAR_UPDOWN, UP, 16'h0000, 999);
    ev(8'h09, VAR_UPDOWN, DN, 16'h0000, 998);
    ev(8'h09, VAR_UPDOWN, NO, 16'h0000, 998);
    ev(8'h09, VAR_UPDOWN, UP | DN, 16'h0000, 998);
    ev(8'h0A, VAR_UPDOWN, DN, 16'h0000, 0);
  endtask

  task automatic t_clear();
    ev(8'h07, VAR_UPDOWN, CL, 16'h0000, 0);
    ev(8'h07, VAR_UPDOWN, CL | UP, 16'h0000, 0);
    ev(8'h0B, VAR_UPONLY, ST, 16'h0050, 50);
    ev(8'h0B, VAR_UPONLY, CL, 16'h0000, 0);
    ev(8'h0B, VAR_UPONLY, CL | UP, 16'h0000, 1);
    ev(8'h0B, VAR_UPONLY, DN, 16'h0000, 1);
    ev(8'h0B, VAR_UPONLY, ST, 16'h0999, 999);
    ev(8'h0B, VAR_UPONLY, ST | UP, 16'h0000, 999);
  endtask

  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_sweep();
    t_walk();
    t_preset();
    t_limits();
    t_clear();
    t_reset();
    test_done();
  end
endmodule
